// file: design/ustw_pkg.sv
// package for the device-mode command register middle fields (bits 4 to 13)
// assumes an apb slave at 32-bit data, one aligned word per register
package ustw_pkg;
	// register byte offsets
	localparam logic [11:0] USTW_CMD_OFF = 12'h000;
	localparam logic [11:0] USTW_SETUP_EVT_OFF = 12'h004;
	localparam logic [11:0] USTW_MODE_OFF = 12'h008;
	// command register field positions
	localparam int USTW_PSE_BIT = 4;
	localparam int USTW_ASE_BIT = 5;
	localparam int USTW_IAA_BIT = 6;
	localparam int USTW_RSV7_BIT = 7;
	localparam int USTW_ASP_LO = 8;
	localparam int USTW_ASP_HI = 9;
	localparam int USTW_RSV10_BIT = 10;
	localparam int USTW_ASYNC_PARK_ENABLE_BIT = 11;
	localparam int USTW_RSV12_BIT = 12;
	localparam int USTW_SETUP_TRIP_WIRE_BIT = 13;
	// mode register field: setup lockout off when one
	localparam int USTW_LOCKOUT_OFF_BIT = 0;
	// reset values
	localparam logic USTW_PSE_RST = 1'b0;
	localparam logic USTW_ASE_RST = 1'b0;
	localparam logic USTW_SETUP_TRIP_WIRE_RST = 1'b0;
	localparam logic [1:0] USTW_ASP_RST = 2'h0;
	localparam logic USTW_ASYNC_PARK_ENABLE_RST = 1'b0;
	localparam logic USTW_LOCKOUT_OFF_RST = 1'b0;
	// setup payload size in bytes
	localparam int USTW_SETUP_BYTES = 8;
	// copy tracker states
	typedef enum logic [1:0] {USTW_IDLE, USTW_COPY, USTW_HAZ} ustw_copy_t;
endpackage : ustw_pkg

// file: design/ustw_if.sv
// interface between the register bank and the trip wire tracker
// assumes both ends on pclk
`timescale 1ns/10ps
interface ustw_trip_if;
	logic sw_set;
	logic sw_clr;
	logic setup_arrive;
	logic lockout_off;
	logic hw_clear;
	logic trip;
	modport bank (output sw_set, output sw_clr, output setup_arrive, output lockout_off,
		input hw_clear, input trip);
	modport trk (input sw_set, input sw_clr, input setup_arrive, input lockout_off,
		output hw_clear, output trip);
endinterface : ustw_trip_if

// file: design/ustw_trip.sv
// setup trip wire semaphore with hazard detection
// assumes all inputs are synchronous to pclk
`timescale 1ns/10ps
module ustw_trip
	import ustw_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	ustw_trip_if.trk t
);
	logic trip;
	logic next_trip;
	logic hw_clear;
	logic next_hw_clear;
	ustw_copy_t state;
	ustw_copy_t next_state;
	logic hazard;

	// hazard: new setup lands in the queue head while a copy is open
	assign hazard = trip && t.setup_arrive && t.lockout_off;

	// next semaphore and tracker state
	always_comb
	begin
		next_trip = trip;
		next_hw_clear = 1'b0;
		next_state = state;
		if (hazard)
		begin
			next_trip = 1'b0;
			next_hw_clear = 1'b1;
		end
		else if (t.sw_set)
			next_trip = 1'b1;
		else if (t.sw_clr)
			next_trip = 1'b0;
		case (state)
			USTW_IDLE: if (next_trip) next_state = USTW_COPY;
			USTW_COPY:
			begin
				if (hazard)
					next_state = USTW_HAZ;
				else if (!next_trip)
					next_state = USTW_IDLE;
			end
			USTW_HAZ: if (next_trip) next_state = USTW_COPY; else next_state = USTW_IDLE;
			default: next_state = USTW_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trip <= USTW_SETUP_TRIP_WIRE_RST;
			hw_clear <= 1'b0;
			state <= USTW_IDLE;
		end
		else
		begin
			trip <= next_trip;
			hw_clear <= next_hw_clear;
			state <= next_state;
		end
	end

	assign t.trip = trip;
	assign t.hw_clear = hw_clear;

	a_hazard_clears: assert property (@(posedge pclk) disable iff (!presetn)
		hazard |=> !trip && hw_clear) else $error("hazard did not clear trip wire");
	a_lockout_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		(trip && t.setup_arrive && !t.lockout_off && !t.sw_clr) |=> trip)
		else $error("trip wire cleared under lockout");
	a_clear_beats_set: assert property (@(posedge pclk) disable iff (!presetn)
		(hazard && t.sw_set) |=> !trip) else $error("set won over hazard clear");
	a_set_takes: assert property (@(posedge pclk) disable iff (!presetn)
		(t.sw_set && !hazard) |=> trip) else $error("software set lost");
	a_idle_no_haz: assert property (@(posedge pclk) disable iff (!presetn)
		!trip |=> !hw_clear) else $error("hazard flagged without open copy");
	// the tracker sits in its hazard state exactly while the clear pulse stands
	a_haz_state: assert property (@(posedge pclk) disable iff (!presetn)
		hw_clear == (state == USTW_HAZ)) else $error("tracker state and clear pulse differ");
endmodule : ustw_trip

// file: design/ustw_top.sv
// Notes on behaviour
// - hardware clears wire on a setup hazard
// - hazard is new setup during open copy
// - lockout on means no hazard clear
// - protected payload is eight bytes, control queue
// - schedule enables inert, reset to zero
// - park count and park enable inert
// file: apb register bank for the device-mode command register fields
// assumes an apb master on pclk and a setup-arrival pulse from the
// endpoint logic on the same clock
`timescale 1ns/10ps
module ustw_top
	import ustw_pkg::*;
#(
	parameter int SETUP_BYTES = USTW_SETUP_BYTES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic setup_arrive,
	output logic setup_trip_wire,
	output logic setup_hazard
);
	// payload size is fixed by the setup packet format
	if (SETUP_BYTES != USTW_SETUP_BYTES)
	begin : g_bad_payload
		$error("setup payload must be 8 bytes");
	end

	ustw_trip_if tif ();

	logic periodic_sched_enable;
	logic async_sched_enable;
	logic [1:0] async_park_count;
	logic async_park_enable;
	logic lockout_off;
	logic [31:0] setup_count;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic next_pse;
	logic next_ase;
	logic [1:0] next_asp;
	logic next_async_park_enable;
	logic next_lockout_off;
	logic [31:0] next_setup_count;
	logic wr;
	logic rd;
	logic hit;
	logic [31:0] cmd_value;

	assign wr = psel && penable && pwrite;
	// read data is fetched in the setup cycle so that it stands with pready
	assign rd = psel && !penable && !pwrite;
	assign hit = (paddr == USTW_CMD_OFF) || (paddr == USTW_SETUP_EVT_OFF) ||
		(paddr == USTW_MODE_OFF);

	// software-side strobes to the tracker
	assign tif.sw_set = wr && (paddr == USTW_CMD_OFF) && pwdata[USTW_SETUP_TRIP_WIRE_BIT];
	assign tif.sw_clr = wr && (paddr == USTW_CMD_OFF) && !pwdata[USTW_SETUP_TRIP_WIRE_BIT];
	assign tif.setup_arrive = setup_arrive;
	assign tif.lockout_off = lockout_off;

	// command readback: doorbell and reserved bits read zero
	always_comb
	begin
		cmd_value = 32'h0000_0000;
		cmd_value[USTW_PSE_BIT] = periodic_sched_enable;
		cmd_value[USTW_ASE_BIT] = async_sched_enable;
		cmd_value[USTW_ASP_HI:USTW_ASP_LO] = async_park_count;
		cmd_value[USTW_ASYNC_PARK_ENABLE_BIT] = async_park_enable;
		cmd_value[USTW_SETUP_TRIP_WIRE_BIT] = tif.trip;
	end

	// next register values; inert fields store only, steer nothing
	always_comb
	begin
		next_pse = periodic_sched_enable;
		next_ase = async_sched_enable;
		next_asp = async_park_count;
		next_async_park_enable = async_park_enable;
		next_lockout_off = lockout_off;
		next_setup_count = setup_count;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (setup_arrive)
			next_setup_count = setup_count + 32'h0000_0001;
		if (wr && paddr == USTW_CMD_OFF)
		begin
			next_pse = pwdata[USTW_PSE_BIT];
			next_ase = pwdata[USTW_ASE_BIT];
			next_asp = pwdata[USTW_ASP_HI:USTW_ASP_LO];
			next_async_park_enable = pwdata[USTW_ASYNC_PARK_ENABLE_BIT];
		end
		if (wr && paddr == USTW_MODE_OFF)
			next_lockout_off = pwdata[USTW_LOCKOUT_OFF_BIT];
		if (rd)
		begin
			case (paddr)
				USTW_CMD_OFF: next_prdata = cmd_value;
				USTW_SETUP_EVT_OFF: next_prdata = setup_count;
				USTW_MODE_OFF: next_prdata = {31'h0, lockout_off};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		if (psel && !penable && !hit)
			next_pslverr = 1'b1; // registered together with pready
	end

	// register stage; pready follows setup so every access completes with no wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			periodic_sched_enable <= USTW_PSE_RST;
			async_sched_enable <= USTW_ASE_RST;
			async_park_count <= USTW_ASP_RST;
			async_park_enable <= USTW_ASYNC_PARK_ENABLE_RST;
			lockout_off <= USTW_LOCKOUT_OFF_RST;
			setup_count <= 32'h0000_0000;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
			setup_trip_wire <= 1'b0;
			setup_hazard <= 1'b0;
		end
		else
		begin
			periodic_sched_enable <= next_pse;
			async_sched_enable <= next_ase;
			async_park_count <= next_asp;
			async_park_enable <= next_async_park_enable;
			lockout_off <= next_lockout_off;
			setup_count <= next_setup_count;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			pready <= psel && !penable;
			setup_trip_wire <= tif.trip;
			setup_hazard <= tif.hw_clear;
		end
	end

	ustw_trip u_trip (
		.pclk(pclk),
		.presetn(presetn),
		.t(tif.trk)
	);

	// apb access completes only with pready high
	a_access_done: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready) else $error("no ready after setup");
	a_sched_reset: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> !periodic_sched_enable && !async_sched_enable)
		else $error("schedule enables not zero after reset");
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!cmd_value[USTW_RSV7_BIT] && !cmd_value[USTW_RSV10_BIT] && !cmd_value[USTW_RSV12_BIT]
		&& !cmd_value[USTW_IAA_BIT]) else $error("reserved bit reads nonzero");
	// read data and error only stand in the access cycle
	a_rdata_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000) else $error("read data outside access");
	a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready) else $error("slave error without ready");
endmodule : ustw_top

// file: tb/test_usb_device_setup_tripwire.sv
// testbench for the device-mode command register fields and setup trip wire
// assumes the ustw_top apb slave answering with pready after each setup cycle
`timescale 1ns/10ps
module test_usb_device_setup_tripwire
	import ustw_pkg::*;
();
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic setup_arrive = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic pready;
	logic pslverr;
	logic err;
	logic setup_trip_wire;
	logic setup_hazard;
	int error_cnt = 0;
	int checks_done = 0;
	int haz_cnt = 0;
	// fields that hold what software writes; doorbell and reserved bits read zero
	localparam logic [31:0] TRIP = 32'h1 << USTW_SETUP_TRIP_WIRE_BIT;
	localparam logic [31:0] RW = (32'h1 << USTW_PSE_BIT) | (32'h1 << USTW_ASE_BIT)
		| (32'h3 << USTW_ASP_LO) | (32'h1 << USTW_ASYNC_PARK_ENABLE_BIT) | TRIP;

	// 250 MHz clock
	always #2 pclk = ~pclk;

	// counts cycles in which the hazard pulse is high
	always @(posedge pclk)
		if (setup_hazard === 1'b1)
			haz_cnt <= haz_cnt + 1;

	ustw_top #(.SETUP_BYTES(USTW_SETUP_BYTES)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .setup_arrive(setup_arrive),
		.setup_trip_wire(setup_trip_wire), .setup_hazard(setup_hazard));

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one apb transfer; arr pulses setup arrival in the access cycle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic arr);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		setup_arrive <= arr;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			error_cnt++;
			give_verdict;
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		setup_arrive <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0, 1'b0);
		chk(name, exp, rdata);
	endtask : rd

	// lone setup arrival, then room for the delayed hazard pulse
	task arrive;
		setup_arrive <= 1'b1;
		@(posedge pclk);
		setup_arrive <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : arrive

	// main sequence
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(USTW_CMD_OFF, 32'h0, "cmd reset");
		rd(USTW_MODE_OFF, 32'h0, "mode reset");
		$display("test reset done");
		wr(USTW_CMD_OFF, RW);
		rd(USTW_CMD_OFF, RW, "cmd fields");
		chk("trip out", 32'h1, {31'h0, setup_trip_wire});
		$display("test fields done");
		arrive;
		rd(USTW_CMD_OFF, RW, "cmd lockout on");
		chk("hazards", 32'h0, 32'(haz_cnt));
		rd(USTW_SETUP_EVT_OFF, 32'h1, "arrivals");
		$display("test lockout done");
		wr(USTW_MODE_OFF, 32'h1);
		arrive;
		rd(USTW_CMD_OFF, RW & ~TRIP, "cmd hazard");
		chk("hazards", 32'h1, 32'(haz_cnt));
		chk("trip out", 32'h0, {31'h0, setup_trip_wire});
		arrive;
		chk("hazards idle", 32'h1, 32'(haz_cnt));
		$display("test hazard done");
		wr(USTW_CMD_OFF, TRIP);
		apb(1'b1, USTW_CMD_OFF, TRIP, 1'b1);
		repeat (4) @(posedge pclk);
		rd(USTW_CMD_OFF, 32'h0, "cmd set vs clear");
		chk("hazards", 32'h2, 32'(haz_cnt));
		rd(USTW_SETUP_EVT_OFF, 32'h4, "arrivals");
		$display("test precedence done");
		rd(12'h00c, 32'h0, "unmapped data");
		chk("pslverr", 32'h1, {31'h0, err});
		$display("test unmapped done");
		give_verdict;
	end
endmodule : test_usb_device_setup_tripwire
